// ==== brt_block_xfer.sv ====
`timescale 1ns/1ps
// Function
// - Opcode 034 loads consecutive memory words into address-save entries.
// - Loads start at the memory address held in the base address register.
// - First address-save entry index is the first_entry_index field.
// - Address-save loads keep only the low 24 bits of each word.
// - Address-save load index wraps from entry 77 octal to 00.
// - Word count is the low 7 bits of the selected count register.
// - Counts above 64 keep wrapping, revisiting earlier entries.
// - Zero count finishes without any memory or register access.
// - With i equal to 0 the base register gives address and count.
// - Opcode 035 stores consecutive address-save entries to memory.
// - Stores start at the memory address in the base address register.
// - Each stored entry goes to the next consecutive memory address.
// - Address-save store index wraps from entry 77 octal to 00.
// - Opcode 036 loads consecutive memory words into scalar-save entries.
// - First scalar-save entry index is the first_entry_index field.
// - Scalar-save load index wraps from entry 77 octal to 00.
// - Opcode 037 stores scalar-save entries from the base address onward.
// - Scalar-save store index wraps from entry 77 octal to 00.
module brt_block_xfer (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic instr_valid_i,
  input wire logic [brt_pkg::INSTR_W-1:0] instr_i,
  output logic instr_ready_o,
  input wire logic [brt_pkg::NAREG-1:0][brt_pkg::ADDR_W-1:0] a_regs_i,
  output logic busy_o,
  output logic done_o,
  output logic mem_valid_o,
  input wire logic mem_ready_i,
  output logic mem_we_o,
  output logic [brt_pkg::ADDR_W-1:0] mem_addr_o,
  output logic [brt_pkg::DATA_W-1:0] mem_wdata_o,
  input wire logic mem_rvalid_i,
  input wire logic [brt_pkg::DATA_W-1:0] mem_rdata_i,
  input wire logic core_sel_t_i,
  input wire logic core_we_i,
  input wire logic [brt_pkg::IDX_W-1:0] core_addr_i,
  input wire logic [brt_pkg::DATA_W-1:0] core_wdata_i,
  output logic [brt_pkg::DATA_W-1:0] core_rdata_o
);
  import brt_pkg::*;

  brt_file_if #(.W(ASAVE_W)) a_if ();
  brt_file_if #(.W(DATA_W)) t_if ();

  brt_regfile #(.W(ASAVE_W), .DEPTH(NREG)) u_afile (
    .clk_i(clk_i),
    .port(a_if.store)
  );
  brt_regfile #(.W(DATA_W), .DEPTH(NREG)) u_tfile (
    .clk_i(clk_i),
    .port(t_if.store)
  );

  // Instruction decode
  logic [6:0] opcode;
  logic [2:0] i_fld;
  logic [CNT_W-1:0] cnt_in;
  logic is_xfer;
  logic start_go;
  logic start_zero;

  assign opcode = instr_i[OP_MSB:OP_LSB];
  assign i_fld = instr_i[I_MSB:I_LSB];
  // Index 0 of the address file is the base register itself
  assign cnt_in = a_regs_i[i_fld][CNT_W-1:0];
  assign is_xfer = (opcode == OP_ALOAD) || (opcode == OP_ASTORE) ||
                   (opcode == OP_TLOAD) || (opcode == OP_TSTORE);

  // Sequencer state
  brt_state_t state_reg, state_next;
  logic store_reg, store_next;
  logic tfile_reg, tfile_next;
  logic [IDX_W-1:0] idx_reg, idx_next;
  logic [IDX_W-1:0] widx_reg, widx_next;
  logic [CNT_W-1:0] left_reg, left_next;
  logic [CNT_W-1:0] resp_reg, resp_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic done_reg, done_next;

  // Buffer signals
  logic push;
  logic in_ready;
  logic [DATA_W-1:0] push_data;
  logic pop;
  logic [1:0] cnt_reg, cnt_next;
  logic [ENT_W-1:0] e0_reg, e0_next;
  logic [ENT_W-1:0] e1_reg, e1_next;

  logic load_wr;

  assign instr_ready_o = (state_reg == BRT_IDLE);
  assign start_go = instr_valid_i && instr_ready_o && is_xfer &&
                    (cnt_in != 7'h00);
  assign start_zero = instr_valid_i && instr_ready_o && is_xfer &&
                      (cnt_in == 7'h00);
  assign busy_o = (state_reg != BRT_IDLE);
  assign done_o = done_reg;
  assign load_wr = busy_o && !store_reg && mem_rvalid_i;

  // Stores push the entry read the cycle before; loads push bare requests
  always_comb begin
    if (!store_reg) begin
      push_data = '0;
    end else if (tfile_reg) begin
      push_data = t_if.rdata;
    end else begin
      push_data = {{(DATA_W-ASAVE_W){1'b0}}, a_if.rdata};
    end
  end

  assign push = (state_reg == BRT_PUSH) && in_ready;

  always_comb begin
    state_next = state_reg;
    store_next = store_reg;
    tfile_next = tfile_reg;
    idx_next = idx_reg;
    widx_next = widx_reg;
    left_next = left_reg;
    resp_next = resp_reg;
    addr_next = addr_reg;
    done_next = 1'b0;
    case (state_reg)
      BRT_IDLE: begin
        if (start_zero) begin
          done_next = 1'b1;
        end else if (start_go) begin
          store_next = opcode[0];
          tfile_next = opcode[1];
          idx_next = instr_i[IDX_MSB:IDX_LSB];
          widx_next = instr_i[IDX_MSB:IDX_LSB];
          left_next = cnt_in;
          resp_next = opcode[0] ? 7'h00 : cnt_in;
          addr_next = a_regs_i[0];
          state_next = opcode[0] ? BRT_READ : BRT_PUSH;
        end
      end
      BRT_READ: begin
        state_next = BRT_PUSH;
      end
      BRT_PUSH: begin
        if (in_ready) begin
          // Six-bit index rolls 77 octal over to 00 naturally
          idx_next = idx_reg + 6'h01;
          addr_next = addr_reg + 24'h000001;
          left_next = left_reg - 7'h01;
          if (left_reg == 7'h01) begin
            state_next = BRT_DRAIN;
          end else begin
            state_next = store_reg ? BRT_READ : BRT_PUSH;
          end
        end
      end
      BRT_DRAIN: begin
        if (store_reg ? (cnt_reg == 2'h0) : (resp_reg == 7'h00)) begin
          state_next = BRT_IDLE;
          done_next = 1'b1;
        end
      end
      default: begin
        state_next = BRT_IDLE;
      end
    endcase
    if (load_wr) begin
      widx_next = widx_reg + 6'h01;
      resp_next = resp_reg - 7'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_reg <= BRT_IDLE;
      store_reg <= 1'b0;
      tfile_reg <= 1'b0;
      idx_reg <= '0;
      widx_reg <= '0;
      left_reg <= '0;
      resp_reg <= '0;
      addr_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      store_reg <= store_next;
      tfile_reg <= tfile_next;
      idx_reg <= idx_next;
      widx_reg <= widx_next;
      left_reg <= left_next;
      resp_reg <= resp_next;
      addr_reg <= addr_next;
      done_reg <= done_next;
    end
  end

  // Register file ports; the core owns them only while idle
  always_comb begin
    a_if.raddr = busy_o ? idx_reg : core_addr_i;
    t_if.raddr = busy_o ? idx_reg : core_addr_i;
    a_if.we = busy_o ? (load_wr && !tfile_reg) :
              (core_we_i && !core_sel_t_i);
    t_if.we = busy_o ? (load_wr && tfile_reg) :
              (core_we_i && core_sel_t_i);
    a_if.waddr = busy_o ? widx_reg : core_addr_i;
    t_if.waddr = busy_o ? widx_reg : core_addr_i;
    a_if.wdata = busy_o ? mem_rdata_i[ASAVE_W-1:0] :
                 core_wdata_i[ASAVE_W-1:0];
    t_if.wdata = busy_o ? mem_rdata_i : core_wdata_i;
  end

  assign core_rdata_o = core_sel_t_i ? t_if.rdata :
                        {{(DATA_W-ASAVE_W){1'b0}}, a_if.rdata};

  // Two-entry request buffer: a stalled memory port backs up the sequencer
  assign in_ready = (cnt_reg != BUF_DEPTH);
  assign pop = (cnt_reg != 2'h0) && mem_ready_i;

  always_comb begin
    e0_next = e0_reg;
    e1_next = e1_reg;
    cnt_next = cnt_reg;
    if (pop) begin
      e0_next = e1_reg;
    end
    if (push) begin
      if ((cnt_reg == 2'h0) || ((cnt_reg == 2'h1) && pop)) begin
        e0_next = {store_reg, addr_reg, push_data};
      end else begin
        e1_next = {store_reg, addr_reg, push_data};
      end
    end
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_reg <= 2'h0;
      e0_reg <= '0;
      e1_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
      e0_reg <= e0_next;
      e1_reg <= e1_next;
    end
  end

  assign mem_valid_o = (cnt_reg != 2'h0);
  assign mem_we_o = e0_reg[ENT_W-1];
  assign mem_addr_o = e0_reg[DATA_W +: ADDR_W];
  assign mem_wdata_o = e0_reg[DATA_W-1:0];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_zero_done: assert property (start_zero |=> done_o && !busy_o)
    else $error("zero count did not finish at once");
  a_zero_quiet: assert property (
    start_zero |=> !mem_valid_o && !a_if.we && !t_if.we)
    else $error("zero count touched memory or registers");
  a_base_address: assert property (
    start_go |=> addr_reg == $past(a_regs_i[0]))
    else $error("start address not from base register");
  a_count_low7: assert property (
    start_go |=> left_reg == $past(a_regs_i[i_fld][CNT_W-1:0]))
    else $error("word count not from low seven bits");
  a_first_index: assert property (
    start_go |=> idx_reg == $past(instr_i[IDX_MSB:IDX_LSB]))
    else $error("first entry index not from instruction");
  a_index_wrap: assert property (
    push && idx_reg == 6'h3f && left_reg > 7'h01
    |=> idx_reg == 6'h00)
    else $error("entry index did not wrap to zero");
  a_addr_step: assert property (
    push |=> addr_reg == $past(addr_reg) + 24'h000001)
    else $error("memory address not consecutive");
  a_astore_high: assert property (
    push && store_reg && !tfile_reg |-> push_data[DATA_W-1:ASAVE_W] == '0)
    else $error("address-save store high bits not zero");
  a_aload_low24: assert property (
    load_wr && !tfile_reg |-> a_if.we && a_if.wdata == mem_rdata_i[23:0])
    else $error("address-save load not low 24 bits");
  a_tload_full: assert property (
    load_wr && tfile_reg |-> t_if.we && t_if.wdata == mem_rdata_i)
    else $error("scalar-save load word altered");
  a_store_kind: assert property (
    start_go && opcode == OP_TSTORE |=> store_reg && tfile_reg ##1
    state_reg == BRT_PUSH)
    else $error("scalar store not sequenced");
  a_buffer_hold: assert property (
    mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable(mem_addr_o))
    else $error("stalled request changed");

  c_aload_run: cover property (start_go && opcode == OP_ALOAD ##[1:300] done_o);
  c_tstore_stall: cover property (
    store_reg && tfile_reg && mem_valid_o && !mem_ready_i && !in_ready);
  c_wrap: cover property (push && idx_reg == 6'h3f && left_reg > 7'h01);
  c_zero: cover property (start_zero);
endmodule

// ==== brt_pkg.sv ====
package brt_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 64;
  localparam int ASAVE_W = 24;
  localparam int IDX_W = 6;
  localparam int CNT_W = 7;
  localparam int NREG = 64;
  localparam int NAREG = 8;
  localparam int INSTR_W = 16;
  // Instruction fields: opcode, i, j, k
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 9;
  localparam int I_MSB = 8;
  localparam int I_LSB = 6;
  localparam int IDX_MSB = 5;
  localparam int IDX_LSB = 0;
  localparam logic [6:0] OP_ALOAD = 7'h1c;
  localparam logic [6:0] OP_ASTORE = 7'h1d;
  localparam logic [6:0] OP_TLOAD = 7'h1e;
  localparam logic [6:0] OP_TSTORE = 7'h1f;
  // Buffer entry layout: write flag, address, data
  localparam int ENT_W = 1 + ADDR_W + DATA_W;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  typedef enum logic [1:0] {
    BRT_IDLE = 2'b00,
    BRT_READ = 2'b01,
    BRT_PUSH = 2'b10,
    BRT_DRAIN = 2'b11
  } brt_state_t;
endpackage

// ==== brt_file_if.sv ====
`timescale 1ns/1ps
interface brt_file_if #(parameter int W = 24);
  logic we;
  logic [5:0] waddr;
  logic [W-1:0] wdata;
  logic [5:0] raddr;
  logic [W-1:0] rdata;
  modport store (input we, input waddr, input wdata, input raddr,
                 output rdata);
  modport user (output we, output waddr, output wdata, output raddr,
                input rdata);
endinterface

// ==== brt_regfile.sv ====
`timescale 1ns/1ps
module brt_regfile #(
  parameter int W = 24,
  parameter int DEPTH = 64
) (
  input wire logic clk_i,
  brt_file_if.store port
);
  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] rdata_reg;

  // Registered read: data for raddr appear one cycle later
  always_ff @(posedge clk_i) begin
    if (port.we) begin
      mem[port.waddr] <= port.wdata;
    end
    rdata_reg <= mem[port.raddr];
  end

  assign port.rdata = rdata_reg;
endmodule

// ==== brt_mem_model.sv ====
`timescale 1ns/1ps
module brt_mem_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic mem_valid_i,
  output logic mem_ready_o,
  input wire logic mem_we_i,
  input wire logic [23:0] mem_addr_i,
  input wire logic [63:0] mem_wdata_i,
  output logic mem_rvalid_o,
  output logic [63:0] mem_rdata_o
);
  logic [63:0] mem [0:255];
  logic [63:0] pend [$];
  logic [63:0] last = '0;
  int cyc = 0;
  initial begin
    mem_ready_o = 1'b1;
    mem_rvalid_o = 1'b0;
    mem_rdata_o = '1;
  end
  // Only the low address byte is decoded; tests stay inside 256 words
  always @(posedge clk_i) begin
    if (mem_valid_i && mem_ready_o) begin
      if (mem_we_i)
        mem[mem_addr_i[7:0]] = mem_wdata_i;
      else
        pend.push_back(mem[mem_addr_i[7:0]]);
    end
    cyc++;
    #1;
    mem_ready_o = !slow_i || (cyc % 3 == 0);
    if (pend.size() > 0 && (!slow_i || cyc[0])) begin
      last = pend.pop_front();
      mem_rvalid_o = 1'b1;
      mem_rdata_o = last;
    end else begin
      // Data bus floats between answers: show garbage, not the old word
      mem_rvalid_o = 1'b0;
      mem_rdata_o = ~last;
    end
  end
endmodule

// ==== test_block_register_transfer.sv ====
`timescale 1ns/1ps
module test_block_register_transfer;
  import brt_pkg::*;
  logic clk_i = 0, nrst_i = 0, instr_valid_i = 0, slow = 0;
  logic core_sel_t_i = 0, core_we_i = 0;
  logic [INSTR_W-1:0] instr_i = '0;
  logic [NAREG-1:0][ADDR_W-1:0] a_regs_i = '0;
  logic [IDX_W-1:0] core_addr_i = '0;
  logic [DATA_W-1:0] core_wdata_i = '0;
  logic [DATA_W-1:0] core_rdata_o, mem_wdata_o, mem_rdata_i;
  logic instr_ready_o, busy_o, done_o, mem_valid_o, mem_ready_i;
  logic mem_we_o, mem_rvalid_i;
  logic [ADDR_W-1:0] mem_addr_o;
  int n_errors = 0, n_compared = 0, cycles = 0, nreq = 0;

  brt_block_xfer dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .instr_ready_o(instr_ready_o), .a_regs_i(a_regs_i), .busy_o(busy_o),
    .done_o(done_o), .mem_valid_o(mem_valid_o), .mem_ready_i(mem_ready_i),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_rvalid_i(mem_rvalid_i),
    .mem_rdata_i(mem_rdata_i), .core_sel_t_i(core_sel_t_i),
    .core_we_i(core_we_i), .core_addr_i(core_addr_i),
    .core_wdata_i(core_wdata_i), .core_rdata_o(core_rdata_o));

  brt_mem_model m (.clk_i(clk_i), .slow_i(slow),
    .mem_valid_i(mem_valid_o), .mem_ready_o(mem_ready_i),
    .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_rvalid_o(mem_rvalid_i),
    .mem_rdata_o(mem_rdata_i));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (mem_valid_o === 1'b1 && mem_ready_i === 1'b1)
      nreq++;
    cycles++;
    if (cycles > 20000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [63:0] pat(int k);
    return {k[7:0], 56'h0f1e2d3c4b5a69} ^ 64'(k * 7);
  endfunction

  task automatic core_wr(logic sel, int idx, logic [63:0] d);
    core_sel_t_i = sel;
    core_addr_i = 6'(idx);
    core_wdata_i = d;
    core_we_i = 1'b1;
    @(posedge clk_i);
    #1;
    core_we_i = 1'b0;
    // Let an edge pass so back-to-back writes never retoggle the strobe
    @(posedge clk_i);
    #1;
  endtask

  task automatic core_rd(logic sel, int idx, logic [63:0] exp);
    core_sel_t_i = sel;
    core_addr_i = 6'(idx);
    @(posedge clk_i);
    #1;
    check("entry", core_rdata_o, exp);
  endtask

  task automatic run(logic [6:0] op, logic [2:0] i, logic [5:0] first_idx,
                     int exp_req);
    int n = 0;
    nreq = 0;
    instr_i = {op, i, first_idx};
    instr_valid_i = 1'b1;
    @(posedge clk_i);
    #1;
    instr_valid_i = 1'b0;
    check("busy", {63'h0, busy_o}, 64'(exp_req != 0));
    while (done_o !== 1'b1 && n < 2000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check("done", {63'h0, done_o}, 64'h1);
    check("ready", {63'h0, instr_ready_o}, 64'h1);
    check("requests", 64'(nreq), 64'(exp_req));
  endtask

  task automatic t_tstore;
    slow = 1'b1;
    for (int k = 0; k < 3; k++)
      core_wr(1'b1, 62 + k, pat(k));
    a_regs_i[0] = 24'h00000a;
    a_regs_i[2] = 24'hffff83;
    run(OP_TSTORE, 3'h2, 6'h3e, 3);
    for (int k = 0; k < 3; k++)
      check("word", m.mem[10 + k], pat(k));
    $display("scalar-save store finished");
  endtask

  task automatic t_astore;
    slow = 1'b0;
    for (int k = 0; k < 2; k++)
      core_wr(1'b0, (63 + k) % 64, pat(k));
    a_regs_i[0] = 24'h000014;
    a_regs_i[1] = 24'h000002;
    run(OP_ASTORE, 3'h1, 6'h3f, 2);
    for (int k = 0; k < 2; k++)
      check("word", m.mem[20 + k], pat(k) & 64'hffffff);
    $display("address-save store finished");
  endtask

  task automatic t_aload;
    slow = 1'b1;
    for (int k = 0; k < 3; k++)
      m.mem[3 + k] = pat(40 + k);
    a_regs_i[0] = 24'h000003;
    run(OP_ALOAD, 3'h0, 6'h3e, 3);
    for (int k = 0; k < 3; k++)
      core_rd(1'b0, (62 + k) % 64, pat(40 + k) & 64'hffffff);
    $display("address-save load finished");
  endtask

  task automatic t_tload;
    slow = 1'b1;
    for (int k = 0; k < 66; k++)
      m.mem[100 + k] = pat(k);
    a_regs_i[0] = 24'h000064;
    a_regs_i[3] = 24'h000042;
    run(OP_TLOAD, 3'h3, 6'h00, 66);
    for (int e = 0; e < 64; e++)
      core_rd(1'b1, e, e < 2 ? pat(64 + e) : pat(e));
    $display("scalar-save load finished");
  endtask

  task automatic t_zero;
    core_wr(1'b0, 5, 64'h0000000000abcdef);
    a_regs_i[4] = 24'h000080;
    run(OP_ALOAD, 3'h4, 6'h05, 0);
    core_rd(1'b0, 5, 64'h0000000000abcdef);
    $display("zero count finished");
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    t_tstore();
    t_astore();
    t_aload();
    t_tload();
    t_zero();
    stop_test();
  end
endmodule
